// >>> hdl/oag_cfg.svh
// Purpose: Named offsets, reset values and steps of the operand address
//          generator.
// Assumes: Byte addresses on a 32-bit AHB-Lite register bus.
// Notes:   Definitions only.
`ifndef OAG_CFG_SVH
`define OAG_CFG_SVH

`define OAG_OFS_CTRL      8'h00
`define OAG_OFS_PLAIN     8'h04
`define OAG_OFS_PREFIX    8'h08
`define OAG_OFS_SP        8'h0c
`define OAG_OFS_STATUS    8'h10
`define OAG_OFS_PAIRS     8'h40
`define OAG_PAIRS_MASK    8'hc0

`define OAG_CTRL_RBS_LO   0
`define OAG_CTRL_RBS_HI   1

`define OAG_SP_RST        16'h0000
`define OAG_PAIR_RST      16'h0000
`define OAG_BANK_RST      4'h0
`define OAG_STACK_STEP    16'h0002
`define OAG_PTR_STEP      16'h0001
`define OAG_UPPER_IDLE    4'h0

`endif

// >>> hdl/oag_pkg.sv
// Purpose: Types shared by the operand address generator files.
// Assumes: Nothing beyond SystemVerilog packed types.
// Notes:   Offsets and values live in oag_cfg.svh.
`default_nettype none

package oag_pkg;

    typedef enum logic [3:0] {
        OAG_OP_NONE        = 4'h0,
        OAG_OP_PUSH_PAIR   = 4'h1,
        OAG_OP_PUSH_WORD   = 4'h2,
        OAG_OP_POP         = 4'h3,
        OAG_OP_CALL        = 4'h4,
        OAG_OP_RET         = 4'h5,
        OAG_OP_INT_SAVE    = 4'h6,
        OAG_OP_INT_RESTORE = 4'h7,
        OAG_OP_DIRECT      = 4'h8,
        OAG_OP_INDIRECT    = 4'h9,
        OAG_OP_IND_INC     = 4'ha,
        OAG_OP_IND_DEC     = 4'hb,
        OAG_OP_BASED       = 4'hc,
        OAG_OP_BASED_SP    = 4'hd
    } oag_op_t;

    typedef struct packed {
        logic        valid;
        oag_op_t     op;
        logic        prefix;
        logic        write;
        logic [1:0]  pair;
        logic [15:0] addr16;
        logic [7:0]  offset;
        logic [15:0] data;
    } oag_op_req_t;

    typedef struct packed {
        logic        req;
        logic        write;
        logic [15:0] addr;
        logic [15:0] wdata;
    } oag_mem_acc_t;

    typedef enum logic [1:0] {
        OAG_BUS_IDLE = 2'b00,
        OAG_BUS_WAIT = 2'b01,
        OAG_BUS_RESP = 2'b11
    } oag_bus_st_t;

endpackage

`default_nettype wire

// >>> hdl/oag_pair_file.sv
// Purpose: Four banks of four 16-bit register pairs.
// Assumes: One clock; hardware and bus write ports.
// Notes:   A hardware write beats a bus write to the same entry.
`default_nettype none
`include "oag_cfg.svh"

module oag_pair_file #(
    parameter int NUM_BANKS = 4,
    parameter int NUM_PAIRS = 4
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic [3:0]  hw_idx,
    input  wire logic        hw_we,
    input  wire logic [15:0] hw_wd,
    input  wire logic [3:0]  bus_idx,
    input  wire logic        bus_we,
    input  wire logic [15:0] bus_wd,
    input  wire logic [3:0]  op_idx,
    output logic      [15:0] op_rd,
    output logic      [15:0] bus_rd
);
    if (NUM_BANKS * NUM_PAIRS != 16) begin : g_chk
        $error("Pair file must hold exactly sixteen entries.");
    end

    logic [15:0] pair_q [16];
    logic [15:0] pair_d [16];

    for (genvar i = 0; i < 16; i++) begin : g_ent
        always_comb begin
            pair_d[i] = pair_q[i];
            if (hw_we && hw_idx == 4'(i)) begin
                pair_d[i] = hw_wd;
            end else if (bus_we && bus_idx == 4'(i)) begin
                pair_d[i] = bus_wd;
            end
        end
        always_ff @(posedge clk) begin
            if (srst) begin
                pair_q[i] <= `OAG_PAIR_RST;
            end else begin
                pair_q[i] <= pair_d[i];
            end
        end
    end

    assign op_rd  = pair_q[op_idx];
    assign bus_rd = pair_q[bus_idx];
endmodule

`default_nettype wire

// >>> hdl/oag_ea_calc.sv
// Purpose: Combinational effective address and pointer update.
// Assumes: Pair value already taken from the selected register bank.
// Notes:   All sums wrap within sixteen bits.
`default_nettype none
`include "oag_cfg.svh"

module oag_ea_calc (
    input  wire oag_pkg::oag_op_req_t req,
    input  wire logic [15:0]          pair_val,
    input  wire logic [15:0]          sp,
    input  wire logic [3:0]           plain_bank,
    input  wire logic [3:0]           prefix_bank,
    output logic      [15:0]          ea,
    output logic      [3:0]           upper,
    output logic                      mem_write,
    output logic      [15:0]          wdata,
    output logic                      sp_we,
    output logic      [15:0]          sp_wd,
    output logic                      pair_we,
    output logic      [15:0]          pair_wd
);
    logic [15:0] sp_dec;
    assign sp_dec = sp - `OAG_STACK_STEP;

    always_comb begin
        ea        = req.addr16;
        upper     = `OAG_UPPER_IDLE;
        mem_write = req.write;
        wdata     = req.data;
        sp_we     = 1'b0;
        sp_wd     = sp;
        pair_we   = 1'b0;
        pair_wd   = pair_val;
        case (req.op)
            oag_pkg::OAG_OP_PUSH_PAIR: begin
                ea        = sp_dec; // R1 R2 R3
                sp_we     = 1'b1;   // R3
                sp_wd     = sp_dec;
                mem_write = 1'b1;
                wdata     = pair_val;
            end
            oag_pkg::OAG_OP_PUSH_WORD, oag_pkg::OAG_OP_CALL,
            oag_pkg::OAG_OP_INT_SAVE: begin
                ea        = sp_dec; // R1 R2
                sp_we     = 1'b1;
                sp_wd     = sp_dec;
                mem_write = 1'b1;
            end
            oag_pkg::OAG_OP_POP, oag_pkg::OAG_OP_RET,
            oag_pkg::OAG_OP_INT_RESTORE: begin
                ea        = sp; // R1 R2
                sp_we     = 1'b1;
                sp_wd     = sp + `OAG_STACK_STEP;
                mem_write = 1'b0;
            end
            oag_pkg::OAG_OP_DIRECT: begin
                ea = req.addr16; // R11
            end
            oag_pkg::OAG_OP_INDIRECT: begin
                ea = pair_val; // R12
            end
            oag_pkg::OAG_OP_IND_INC: begin
                ea      = pair_val; // R12
                pair_we = 1'b1;     // R13
                pair_wd = pair_val + `OAG_PTR_STEP;
            end
            oag_pkg::OAG_OP_IND_DEC: begin
                ea      = pair_val; // R12
                pair_we = 1'b1;     // R13
                pair_wd = pair_val - `OAG_PTR_STEP;
            end
            oag_pkg::OAG_OP_BASED: begin
                ea = pair_val + {8'h00, req.offset}; // R14 R15 R16
            end
            oag_pkg::OAG_OP_BASED_SP: begin
                ea = sp + {8'h00, req.offset}; // R14 R15 R16
            end
            default: begin
                mem_write = 1'b0;
            end
        endcase
        // Only the six expansion-capable modes drive the bank out.
        if (req.op >= oag_pkg::OAG_OP_DIRECT &&
            req.op <= oag_pkg::OAG_OP_BASED_SP) begin // R5
            upper = req.prefix ? prefix_bank : plain_bank; // R7 R8 R18
        end
    end
endmodule

`default_nettype wire

// >>> hdl/oag_top.sv
// Purpose: Operand address generator with an AHB-Lite register slave.
// Assumes: Decoder requests arrive on CLOCK; one request per cycle.
// Notes:   Each bus transfer takes one wait state.
//
// Contract
// R1: Stack accesses address memory with the current stack pointer.
// R2: Push, pop, call, return and interrupt save/restore use stack addressing.
// R3: Pair push first lowers the stack pointer by two, then writes there.
// R4: Software keeps the stack out of special and ROM areas.
// R5: Bank extension is output only for the expansion-capable modes.
// R6: Software loads the bank register before touching the expansion area.
// R7: Plain bank value drives upper lines for unprefixed expansion accesses.
// R8: Prefixed bank value drives upper lines for prefixed accesses only.
// R9: Each bank register holds its value until software rewrites it.
// R10: Software keeps the plain bank at zero when expansion is unused.
// R11: Direct mode takes the sixteen-bit address from the instruction.
// R12: Indirect mode uses the chosen pair of the flag-selected bank.
// R13: Auto increment or decrement adjusts the pointer pair by one after.
// R14: Based mode adds an instruction offset to the chosen base pair.
// R15: The eight-bit offset is zero-extended before the addition.
// R16: The based sum wraps in sixteen bits, carry dropped.
// R17: Reduced variant hardwires the plain bank register to zero.
// R18: Bank value sits above the effective address as a 20-bit address.
`default_nettype none
`include "oag_cfg.svh"

module oag_top #(
    parameter bit REDUCED_VARIANT = 1'b0
) (
    input  wire logic                 CLOCK,
    input  wire logic                 SRST,
    input  wire logic                 HSEL,
    input  wire logic [31:0]          HADDR,
    input  wire logic [1:0]           HTRANS,
    input  wire logic                 HWRITE,
    input  wire logic [2:0]           HSIZE,
    input  wire logic [31:0]          HWDATA,
    input  wire logic                 HREADY,
    output logic      [31:0]          HRDATA,
    output logic                      HREADYOUT,
    output logic                      HRESP,
    input  wire oag_pkg::oag_op_req_t OP_REQ,
    output oag_pkg::oag_mem_acc_t     MEM_ACC,
    output logic      [3:0]           UPPER_ADDRESS_LINES
);
    // Bus slave state.
    oag_pkg::oag_bus_st_t st_q, st_d;
    logic [7:0]  baddr_q, baddr_d;
    logic        bwrite_q, bwrite_d;
    logic [31:0] hrdata_q, hrdata_d;
    logic        hready_q, hready_d;
    logic        hresp_q;

    // Software visible state.
    logic [1:0]  bank_sel_q, bank_sel_d;
    logic [3:0]  plain_bank_register_q, plain_bank_register_d;
    logic [3:0]  prefixed_bank_register_q, prefixed_bank_register_d;
    logic [15:0] stack_pointer_q, stack_pointer_d;
    logic [19:0] last_ea_q, last_ea_d;

    // Memory side outputs.
    oag_pkg::oag_mem_acc_t mem_q, mem_d;
    logic [3:0]  upper_q, upper_d;

    logic        accept;
    logic        bus_we;
    logic [31:0] rd_mux;
    logic [15:0] pair_op_rd, pair_bus_rd;
    logic [15:0] ea;
    logic [3:0]  ea_upper;
    logic        ea_write, sp_we, pair_we;
    logic [15:0] ea_wdata, sp_wd, pair_wd;
    logic [3:0]  op_idx;
    logic        op_go;

    assign accept = HSEL && HTRANS[1] && HREADY;
    assign bus_we = (st_q == oag_pkg::OAG_BUS_WAIT) && bwrite_q;
    assign op_go  = OP_REQ.valid;
    // Pair chosen inside the bank picked by the two select flags.
    assign op_idx = {bank_sel_q, OP_REQ.pair}; // R12

    oag_pair_file #(
        .NUM_BANKS (4),
        .NUM_PAIRS (4)
    ) u_pairs (
        .clk     (CLOCK),
        .srst    (SRST),
        .hw_idx  (op_idx),
        .hw_we   (op_go && pair_we), // R13
        .hw_wd   (pair_wd),
        .bus_idx (baddr_q[5:2]),
        .bus_we  (bus_we && (baddr_q & `OAG_PAIRS_MASK) == `OAG_OFS_PAIRS),
        .bus_wd  (HWDATA[15:0]),
        .op_idx  (op_idx),
        .op_rd   (pair_op_rd),
        .bus_rd  (pair_bus_rd)
    );

    oag_ea_calc u_ea (
        .req         (OP_REQ),
        .pair_val    (pair_op_rd),
        .sp          (stack_pointer_q),
        .plain_bank  (plain_bank_register_q),
        .prefix_bank (prefixed_bank_register_q),
        .ea          (ea),
        .upper       (ea_upper),
        .mem_write   (ea_write),
        .wdata       (ea_wdata),
        .sp_we       (sp_we),
        .sp_wd       (sp_wd),
        .pair_we     (pair_we),
        .pair_wd     (pair_wd)
    );

    // Read multiplexer; unmapped offsets read as zero.
    always_comb begin
        rd_mux = 32'h0000_0000;
        if ((baddr_q & `OAG_PAIRS_MASK) == `OAG_OFS_PAIRS) begin
            rd_mux = {16'h0000, pair_bus_rd};
        end else begin
            case (baddr_q)
                `OAG_OFS_CTRL:   rd_mux = {30'h0, bank_sel_q};
                `OAG_OFS_PLAIN:  rd_mux = {28'h000_0000,
                                           plain_bank_register_q};
                `OAG_OFS_PREFIX: rd_mux = {28'h000_0000,
                                           prefixed_bank_register_q};
                `OAG_OFS_SP:     rd_mux = {16'h0000, stack_pointer_q};
                `OAG_OFS_STATUS: rd_mux = {12'h000, last_ea_q};
                default:         rd_mux = 32'h0000_0000;
            endcase
        end
    end

    // Bus handshake and register writes.
    always_comb begin
        st_d     = st_q;
        baddr_d  = baddr_q;
        bwrite_d = bwrite_q;
        hrdata_d = hrdata_q;
        hready_d = hready_q;
        bank_sel_d               = bank_sel_q;
        plain_bank_register_d    = plain_bank_register_q;
        prefixed_bank_register_d = prefixed_bank_register_q;
        stack_pointer_d          = stack_pointer_q;
        case (st_q)
            oag_pkg::OAG_BUS_IDLE, oag_pkg::OAG_BUS_RESP: begin
                hready_d = 1'b1;
                st_d     = oag_pkg::OAG_BUS_IDLE;
                if (accept) begin
                    baddr_d  = HADDR[7:0];
                    bwrite_d = HWRITE && (HSIZE == 3'h2);
                    hready_d = 1'b0;
                    st_d     = oag_pkg::OAG_BUS_WAIT;
                end
            end
            oag_pkg::OAG_BUS_WAIT: begin
                hrdata_d = rd_mux;
                hready_d = 1'b1;
                st_d     = oag_pkg::OAG_BUS_RESP;
                if (bwrite_q) begin
                    case (baddr_q)
                        `OAG_OFS_CTRL: begin
                            bank_sel_d = {HWDATA[`OAG_CTRL_RBS_HI],
                                          HWDATA[`OAG_CTRL_RBS_LO]};
                        end
                        `OAG_OFS_PLAIN:  plain_bank_register_d = HWDATA[3:0];
                        `OAG_OFS_PREFIX: begin
                            prefixed_bank_register_d = HWDATA[3:0];
                        end
                        `OAG_OFS_SP:     stack_pointer_d = HWDATA[15:0];
                        default: begin
                        end
                    endcase
                end
            end
            default: begin
                st_d     = oag_pkg::OAG_BUS_IDLE;
                hready_d = 1'b1;
            end
        endcase
        // A stack operation in the same cycle wins over a bus write.
        if (op_go && sp_we) begin
            stack_pointer_d = sp_wd; // R3
        end
        if (REDUCED_VARIANT) begin
            plain_bank_register_d = `OAG_BANK_RST; // R17
        end
    end

    // Memory access outputs; upper lines fall back to zero between accesses.
    always_comb begin
        mem_d       = mem_q;
        mem_d.req   = 1'b0;
        upper_d     = `OAG_UPPER_IDLE;
        last_ea_d   = last_ea_q;
        if (op_go) begin
            mem_d.req   = OP_REQ.op != oag_pkg::OAG_OP_NONE;
            mem_d.write = ea_write;
            mem_d.addr  = ea;
            mem_d.wdata = ea_wdata;
            upper_d     = ea_upper; // R7 R8
            last_ea_d   = {ea_upper, ea}; // R18
        end
    end

    always_ff @(posedge CLOCK) begin
        if (SRST) begin
            st_q     <= oag_pkg::OAG_BUS_IDLE;
            baddr_q  <= 8'h00;
            bwrite_q <= 1'b0;
            hrdata_q <= 32'h0000_0000;
            hready_q <= 1'b1;
            hresp_q  <= 1'b0;
            bank_sel_q               <= 2'h0;
            plain_bank_register_q    <= `OAG_BANK_RST;
            prefixed_bank_register_q <= `OAG_BANK_RST;
            stack_pointer_q          <= `OAG_SP_RST;
            last_ea_q <= 20'h0_0000;
            mem_q     <= '0;
            upper_q   <= `OAG_UPPER_IDLE;
        end else begin
            st_q     <= st_d;
            baddr_q  <= baddr_d;
            bwrite_q <= bwrite_d;
            hrdata_q <= hrdata_d;
            hready_q <= hready_d;
            hresp_q  <= 1'b0;
            bank_sel_q               <= bank_sel_d;
            plain_bank_register_q    <= plain_bank_register_d; // R9
            prefixed_bank_register_q <= prefixed_bank_register_d; // R9
            stack_pointer_q          <= stack_pointer_d;
            last_ea_q <= last_ea_d;
            mem_q     <= mem_d;
            upper_q   <= upper_d;
        end
    end

    assign HRDATA              = hrdata_q;
    assign HREADYOUT           = hready_q;
    assign HRESP               = hresp_q;
    assign MEM_ACC             = mem_q;
    assign UPPER_ADDRESS_LINES = upper_q;

    // The stack is trusted to sit in ordinary RAM; no range check is made.
    // R4 R6 R10

    AST_PUSH_PAIR: assert property (@(posedge CLOCK) disable iff (SRST) // R3
        op_go && OP_REQ.op == oag_pkg::OAG_OP_PUSH_PAIR |=>
        MEM_ACC.req && MEM_ACC.write &&
        MEM_ACC.addr == 16'($past(stack_pointer_q) - `OAG_STACK_STEP) &&
        stack_pointer_q == MEM_ACC.addr)
        else $error("Pair push did not pre-decrement the stack pointer.");

    AST_POP_ADDR: assert property (@(posedge CLOCK) disable iff (SRST) // R1
        op_go && OP_REQ.op == oag_pkg::OAG_OP_POP |=>
        MEM_ACC.addr == $past(stack_pointer_q) && !MEM_ACC.write &&
        UPPER_ADDRESS_LINES == `OAG_UPPER_IDLE)
        else $error("Pop did not address the stack pointer.");

    AST_PLAIN_BANK: assert property (@(posedge CLOCK) disable iff (SRST) // R7
        op_go && !OP_REQ.prefix && OP_REQ.op == oag_pkg::OAG_OP_DIRECT |=>
        UPPER_ADDRESS_LINES == $past(plain_bank_register_q) &&
        MEM_ACC.addr == $past(OP_REQ.addr16))
        else $error("Direct access lost the plain bank.");

    AST_PREFIX_BANK: assert property (@(posedge CLOCK) disable iff (SRST) // R8
        op_go && OP_REQ.prefix && OP_REQ.op == oag_pkg::OAG_OP_INDIRECT |=>
        UPPER_ADDRESS_LINES == $past(prefixed_bank_register_q))
        else $error("Prefixed access lost the prefixed bank.");

    AST_UPPER_IDLE: assert property (@(posedge CLOCK) disable iff (SRST) // R5
        !op_go |=> UPPER_ADDRESS_LINES == `OAG_UPPER_IDLE ##1
        (UPPER_ADDRESS_LINES == `OAG_UPPER_IDLE || $past(op_go)))
        else $error("Upper lines driven outside an access.");

    AST_BASED_WRAP: assert property (@(posedge CLOCK) disable iff (SRST) // R16
        op_go && OP_REQ.op == oag_pkg::OAG_OP_BASED |=>
        MEM_ACC.addr == 16'($past(pair_op_rd) + {8'h00, $past(OP_REQ.offset)}))
        else $error("Based address sum is wrong.");

    AST_POST_INC: assert property (@(posedge CLOCK) disable iff (SRST) // R13
        op_go && OP_REQ.op == oag_pkg::OAG_OP_IND_INC |->
        pair_we && pair_wd == 16'(pair_op_rd + `OAG_PTR_STEP) ##1
        MEM_ACC.addr == $past(pair_op_rd))
        else $error("Post increment misbehaved.");

    AST_BANK_HOLD: assert property (@(posedge CLOCK) disable iff (SRST) // R9
        !(bus_we && baddr_q == `OAG_OFS_PLAIN) |=>
        $stable(plain_bank_register_q))
        else $error("Plain bank changed without a write.");

    AST_REDUCED: assert property (@(posedge CLOCK) disable iff (SRST) // R17
        REDUCED_VARIANT |=> plain_bank_register_q == `OAG_BANK_RST)
        else $error("Reduced variant plain bank not zero.");
endmodule

`default_nettype wire

// >>> verif/oag_mem_model.sv
// Purpose: Data memory on the far side of the operand address generator.
// Assumes: Writes land at the full twenty-bit address the core drives.
// Notes:   Unwritten places read as zero; peeks take one cycle.
`default_nettype none

module oag_mem_model (
    input  wire logic                  clk,
    input  wire oag_pkg::oag_mem_acc_t acc,
    input  wire logic [3:0]            upper,
    input  wire logic [19:0]           peek_addr,
    output logic      [15:0]           peek_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] mem [logic [19:0]];

    // The bank lines sit above the offset, so each bank is its own space.
    always @(posedge clk) begin
        if (acc.req === 1'b1 && acc.write === 1'b1) begin
            mem[{upper, acc.addr}] = acc.wdata;
        end
        peek_data <= mem.exists(peek_addr) ? mem[peek_addr] : 16'h0;
    end
endmodule

`default_nettype wire

// >>> verif/tb.sv
// Purpose: Self-checking bench for the operand address generator.
// Assumes: One op per cycle; register slave answers when it is ready.
// Notes:   Expected accesses queue up and a monitor retires them.
`default_nettype none
`include "oag_cfg.svh"

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                  CLOCK, SRST, HSEL, HWRITE, HREADYOUT, HRESP;
    logic [1:0]            HTRANS, rbs_m;
    logic [2:0]            HSIZE;
    logic [31:0]           HADDR, HWDATA, HRDATA, rd;
    logic [3:0]            UPPER_ADDRESS_LINES, plain_m, pref_m;
    oag_pkg::oag_op_req_t  OP_REQ;
    oag_pkg::oag_mem_acc_t MEM_ACC;
    logic [19:0]           peek_addr, lp_a, last_a;
    logic [15:0]           peek_data, lp_d, sp_m;
    logic [15:0]           pv [16];
    logic [37:0]           expq [$];
    logic [37:0]           e;
    int                    errors, num_checks;

    oag_top DUT (.CLOCK(CLOCK), .SRST(SRST), .HSEL(HSEL), .HADDR(HADDR),
        .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA),
        .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
        .HRESP(HRESP), .OP_REQ(OP_REQ), .MEM_ACC(MEM_ACC),
        .UPPER_ADDRESS_LINES(UPPER_ADDRESS_LINES));
    oag_mem_model mem (.clk(CLOCK), .acc(MEM_ACC),
        .upper(UPPER_ADDRESS_LINES), .peek_addr(peek_addr),
        .peek_data(peek_data));

    always #2 CLOCK = ~CLOCK;

    task automatic chk(input string n, input logic [31:0] s, x);
        num_checks++;
        if (s !== x) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", n, x, s);
        end
    endtask

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Address phase holds until ready is seen, then the data phase does.
    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [2:0] hs);
        @(posedge CLOCK);
        HSEL <= 1'b1;
        HTRANS <= 2'b10;
        HADDR <= {24'h0, a};
        HWRITE <= w;
        HSIZE <= hs;
        do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'b00;
        HWDATA <= d;
        do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
        rd = HRDATA;
        chk("response", 32'(HRESP), 32'h0);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 3'h2);
    endtask

    task automatic rdchk(input string n, input logic [7:0] a,
                         input logic [31:0] x);
        bus(1'b0, a, 32'($urandom), 3'h2);
        chk(n, rd, x);
    endtask

    // Works out the access an op must produce, then issues the op.
    task automatic op(input oag_pkg::oag_op_t k, input logic pf,
                      input logic [15:0] a, input logic [7:0] f,
                      input logic [15:0] d);
        logic [3:0]  n, i, up;
        logic        st, pu, w;
        logic [15:0] ea;
        n = 4'(k);
        i = {rbs_m, n[2:1]};
        st = n < 4'h8;
        pu = n inside {4'h1, 4'h2, 4'h4, 4'h6};
        w = st ? pu : 1'($urandom);
        if (pu) sp_m -= 16'h2;
        ea = st ? sp_m : (n == 4'h8 ? a : pv[i]);
        if (n == 4'hc) ea = pv[i] + {8'h0, f};
        if (n == 4'hd) ea = sp_m + {8'h0, f};
        if (n == 4'h1) d = pv[i];
        if (n inside {4'h3, 4'h5, 4'h7}) sp_m += 16'h2;
        if (n == 4'ha) pv[i] += 16'h1;
        if (n == 4'hb) pv[i] -= 16'h1;
        up = st ? 4'h0 : (pf ? pref_m : plain_m);
        last_a = {up, ea};
        if (pu) lp_a = last_a;
        if (pu) lp_d = d;
        expq.push_back({pu, w, d, last_a});
        @(posedge CLOCK);
        OP_REQ <= '{1'b1, k, pf, w, n[2:1], a, f, d};
    endtask

    // Every issued op must show up once and in order, whatever its latency.
    always @(posedge CLOCK) begin
        if (SRST === 1'b0 && MEM_ACC.req === 1'b1) begin
            if (expq.size() == 0) begin
                chk("spare access", 32'h1, 32'h0);
            end else begin
                e = expq.pop_front();
                chk("address", 32'({UPPER_ADDRESS_LINES, MEM_ACC.addr}),
                    32'(e[19:0]));
                chk("direction", 32'(MEM_ACC.write), 32'(e[36]));
                if (e[37]) chk("push data", 32'(MEM_ACC.wdata),
                    32'(e[35:20]));
            end
        end else if (SRST === 1'b0) begin
            chk("idle bank lines", 32'(UPPER_ADDRESS_LINES), 32'h0);
        end
    end

    initial begin
        repeat (5000) @(posedge CLOCK);
        errors++;
        tally_and_finish();
    end

    initial begin
        CLOCK = 1'b0;
        SRST = 1'b1;
        {HSEL, HWRITE, HTRANS, HADDR, HWDATA} = '0;
        HSIZE = 3'h2;
        OP_REQ = '0;
        peek_addr = '0;
        sp_m = 16'h1000;
        void'($urandom(74175));
        repeat (4) @(posedge CLOCK);
        SRST <= 1'b0;
        rdchk("reset stack pointer", `OAG_OFS_SP, 32'h0);
        rdchk("unmapped", 8'h20, 32'h0);
        rdchk("plain bank unused", `OAG_OFS_PLAIN, 32'h0);
        plain_m = 4'($urandom_range(14, 1));
        pref_m = ~plain_m;
        wr(`OAG_OFS_PLAIN, 32'(plain_m));
        wr(`OAG_OFS_PREFIX, 32'(pref_m));
        // A byte-wide write must leave the bank value alone.
        bus(1'b1, `OAG_OFS_PLAIN, 32'h0, 3'h0);
        rdchk("plain bank", `OAG_OFS_PLAIN, 32'(plain_m));
        rdchk("prefixed bank", `OAG_OFS_PREFIX, 32'(pref_m));
        wr(`OAG_OFS_SP, 32'(sp_m));
        for (int i = 0; i < 16; i++) begin
            pv[i] = 16'($urandom) | 16'hff00;
            wr(8'(`OAG_OFS_PAIRS + 4 * i), 32'(pv[i]));
        end
        for (int b = 0; b < 4; b++) begin
            rbs_m = 2'(b);
            wr(`OAG_OFS_CTRL, {30'h0, rbs_m});
            for (int k = 1; k < 14; k++) begin
                op(oag_pkg::oag_op_t'(k), 1'(k ^ b), 16'($urandom),
                   8'($urandom) | 8'h80, 16'($urandom));
            end
            @(posedge CLOCK);
            OP_REQ.valid <= 1'b0;
        end
        repeat (3) @(posedge CLOCK);
        chk("queue drained", 32'(expq.size()), 32'h0);
        rdchk("stack pointer", `OAG_OFS_SP, 32'(sp_m));
        for (int i = 0; i < 16; i++) begin
            rdchk("pair", 8'(`OAG_OFS_PAIRS + 4 * i), 32'(pv[i]));
        end
        rdchk("last address", `OAG_OFS_STATUS, 32'(last_a));
        rdchk("plain bank kept", `OAG_OFS_PLAIN, 32'(plain_m));
        peek_addr <= lp_a;
        repeat (2) @(posedge CLOCK);
        chk("stored push", 32'(peek_data), 32'(lp_d));
        tally_and_finish();
    end
endmodule

`default_nettype wire
